// *** dssa_bank.sv ***
// module: status, node address and shutdown override bank behind the serial frame port
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - status word packs inputs, output, option, shutdown, fault
// - fault nibble codes zero to eight, status resets zero
// - answer only frames carrying own address 1..255
// - override zero: shutdown pin alone disables drive
// - override one: drive disabled regardless of pin
// - override volatile, zero after reset
module dssa_bank
   import dssa_pkg::*;
#(
   parameter int GAP_CYCLES = FRAME_GAP_NS / CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic [3:0] input_pins,
   input wire logic option_pin,
   input wire logic shutdown_pin,
   input wire logic output1_state,
   input wire logic [3:0] fault_code,
   output logic drive_disable,
   output logic [7:0] node_address
);
   logic rst_meta_q;
   logic rst_n;
   logic [5:0] pins_sync;
   dssa_status_t status_d;
   dssa_status_t status_q;
   logic [7:0] node_address_q;
   logic override_q;
   dssa_state_t state_q;
   logic [2:0] count_q;
   dssa_frame_t rx_q;
   logic [47:0] tx_q;
   logic [31:0] gap_q;
   wire frame_done;
   wire ck_ok;
   wire addr_ok;
   wire is_read;
   wire [7:0] index_w;
   wire idx_known;
   wire wr_node;
   wire wr_override;
   wire accept;
   wire gap_expired;
   wire [15:0] read_value;
   wire [15:0] reply_value;
   wire [15:0] full_value;
   wire node_value_ok;

   // reset released through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // pins come from outside the clock domain
   dssa_sync #(.WIDTH(6)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({shutdown_pin, option_pin, input_pins}),
      .sync_out(pins_sync)
   );

   // disable is an or, so the override can only add a shutdown, never lift one
   assign drive_disable = override_q | pins_sync[5];

   // status word assembly; reserved bits read zero
   always_comb begin
      status_d.fault_code = fault_code;
      status_d.reserved = '0;
      status_d.shutdown_state = drive_disable;
      status_d.option_fitted = pins_sync[4];
      status_d.output1 = output1_state;
      status_d.inputs = pins_sync[3:0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) status_q <= dssa_status_t'(RST_DRIVE_STATUS_WORD);
      else status_q <= status_d;
   end

   // frame decode
   assign full_value = {rx_data, rx_q.value[7:0]};
   assign frame_done = (state_q == ST_RECEIVE) && rx_valid && (count_q == FRAME_LAST);
   assign ck_ok = ({rx_data, rx_q.checksum[7:0]}
                   == dssa_frame_checksum(rx_q.addr, rx_q.index, rx_q.value));
   assign addr_ok = (rx_q.addr == node_address_q);
   assign is_read = rx_q.index[IDX_READ_BIT];
   assign index_w = {1'b0, rx_q.index[6:0] & IDX_MASK};
   assign idx_known = (index_w == IDX_DRIVE_STATUS_WORD) || (index_w == IDX_NODE_ADDRESS)
                      || (index_w == IDX_SHUTDOWN_OVERRIDE);
   assign accept = frame_done && ck_ok && addr_ok && idx_known;
   assign wr_node = accept && !is_read && (index_w == IDX_NODE_ADDRESS);
   assign wr_override = accept && !is_read && (index_w == IDX_SHUTDOWN_OVERRIDE);
   assign node_value_ok = (rx_q.value[15:8] == 8'h00) && (rx_q.value[7:0] >= NODE_ADDRESS_MIN);
   assign gap_expired = (gap_q >= 32'(GAP_CYCLES));

   // value for a reply; the status read has no side effect
   assign read_value = (index_w == IDX_DRIVE_STATUS_WORD) ? 16'(status_q) :
                       (index_w == IDX_NODE_ADDRESS) ? {8'h00, node_address_q} :
                       {15'h0000, override_q};
   assign reply_value = read_value;

   // writable parameters; out-of-range node addresses are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         node_address_q <= RST_NODE_ADDRESS;
         override_q <= RST_SHUTDOWN_OVERRIDE;
      end else begin
         if (wr_node && node_value_ok) node_address_q <= rx_q.value[7:0];
         if (wr_override) override_q <= rx_q.value[0];
      end
   end
   assign node_address = node_address_q;

   // receive bytes, then shift the reply out; bytes arriving during a reply are lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_RECEIVE;
         count_q <= POS_ADDR;
         rx_q <= '0;
         tx_q <= '0;
         gap_q <= '0;
      end else begin
         case (state_q)
            ST_RECEIVE: begin
               if (rx_valid) begin
                  gap_q <= '0;
                  count_q <= frame_done ? POS_ADDR : 3'(count_q + 3'h1);
                  case (count_q)
                     POS_ADDR: rx_q.addr <= rx_data;
                     POS_INDEX: rx_q.index <= rx_data;
                     POS_VAL_LO: rx_q.value[7:0] <= rx_data;
                     POS_VAL_HI: rx_q.value[15:8] <= rx_data;
                     POS_CK_LO: rx_q.checksum[7:0] <= rx_data;
                     default: rx_q.checksum[15:8] <= rx_data;
                  endcase
                  if (accept) begin
                     state_q <= ST_REPLY;
                     count_q <= POS_ADDR;
                     tx_q <= {dssa_frame_checksum(node_address_q, rx_q.index, (is_read ? reply_value
                              : (wr_override ? {15'h0000, rx_q.value[0]} : (wr_node
                              && node_value_ok ? rx_q.value : reply_value)))),
                              (is_read ? reply_value : (wr_override ? {15'h0000, rx_q.value[0]}
                              : (wr_node && node_value_ok ? rx_q.value : reply_value))),
                              rx_q.index, node_address_q};
                  end
               end else if (count_q != POS_ADDR) begin
                  // a stalled partial frame is dropped so the next one starts clean
                  if (gap_expired) begin
                     count_q <= POS_ADDR;
                     gap_q <= '0;
                  end else begin
                     gap_q <= 32'(gap_q + 32'h1);
                  end
               end
            end
            ST_REPLY: begin
               if (tx_ready) begin
                  tx_q <= {8'h00, tx_q[47:8]};
                  if (count_q == FRAME_LAST) begin
                     state_q <= ST_RECEIVE;
                     count_q <= POS_ADDR;
                  end else begin
                     count_q <= 3'(count_q + 3'h1);
                  end
               end
            end
            default: state_q <= ST_RECEIVE;
         endcase
      end
   end

   assign tx_valid = (state_q == ST_REPLY);
   assign tx_data = tx_q[7:0];

   // checks
   sequence s_wr_override_one;
      wr_override && rx_q.value[0];
   endsequence

   AST_DISABLE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
      !override_q |-> (drive_disable == pins_sync[5]))
      else $error("disable does not follow shutdown pin");
   AST_OVERRIDE_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
      s_wr_override_one |=> override_q && drive_disable)
      else $error("override did not force disable");
   AST_OVERRIDE_RESET: assert property (@(posedge clk)
      !rst_n |-> !override_q)
      else $error("override not zero in reset");
   AST_NODE_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
      node_address_q >= NODE_ADDRESS_MIN)
      else $error("node address left its range");
   AST_NO_REPLY_FOREIGN: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_done && !addr_ok) |=> !tx_valid)
      else $error("reply to foreign address");
   // the status register only follows its sources one edge after reset has gone
   AST_STATUS_BITS: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> (status_q.shutdown_state == $past(drive_disable))
               && (status_q.inputs == $past(pins_sync[3:0])) && (status_q.reserved == '0))
      else $error("status word fields wrong");
   AST_FAULT_NIBBLE: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> status_q.fault_code == $past(fault_code))
      else $error("fault nibble wrong");
   AST_READ_NO_EFFECT: assert property (@(posedge clk) disable iff (!rst_n)
      (accept && is_read) |=> $stable(override_q) && $stable(node_address_q))
      else $error("read changed a parameter");
   AST_REPLY_LEN: assert property (@(posedge clk) disable iff (!rst_n)
      (tx_valid && tx_ready && count_q == FRAME_LAST) |=> !tx_valid)
      else $error("reply longer than frame");
endmodule
`default_nettype wire

// *** dssa_pkg.sv ***
// package: register map, frame layout and status fields of the drive parameter bank
package dssa_pkg;
   // parameter indices carried in the frame index byte
   localparam logic [7:0] IDX_DRIVE_STATUS_WORD = 8'h74;
   localparam logic [7:0] IDX_NODE_ADDRESS = 8'h76;
   localparam logic [7:0] IDX_SHUTDOWN_OVERRIDE = 8'h77;
   // index byte top bit marks a read request
   localparam int IDX_READ_BIT = 7;
   localparam logic [6:0] IDX_MASK = 7'h7f;
   // reset values
   localparam logic [15:0] RST_DRIVE_STATUS_WORD = 16'h0000;
   localparam logic [7:0] RST_NODE_ADDRESS = 8'h01;
   localparam logic RST_SHUTDOWN_OVERRIDE = 1'b0;
   localparam logic [7:0] NODE_ADDRESS_MIN = 8'h01;
   // frame has six bytes: address, index, value lo, value hi, checksum lo, checksum hi
   localparam logic [2:0] FRAME_BYTES = 3'h6;
   localparam logic [2:0] FRAME_LAST = 3'h5;
   localparam logic [2:0] POS_ADDR = 3'h0;
   localparam logic [2:0] POS_INDEX = 3'h1;
   localparam logic [2:0] POS_VAL_LO = 3'h2;
   localparam logic [2:0] POS_VAL_HI = 3'h3;
   localparam logic [2:0] POS_CK_LO = 3'h4;
   // fault codes held in the status nibble
   localparam logic [3:0] FLT_NONE = 4'h0;
   localparam logic [3:0] FLT_STALL = 4'h1;
   localparam logic [3:0] FLT_UNDERVOLT = 4'h2;
   localparam logic [3:0] FLT_OVERVOLT = 4'h3;
   localparam logic [3:0] FLT_OVERCURRENT = 4'h4;
   localparam logic [3:0] FLT_INTERLOCK = 4'h5;
   localparam logic [3:0] FLT_OVERTEMP = 4'h6;
   localparam logic [3:0] FLT_EE_CHECKSUM = 4'h7;
   localparam logic [3:0] FLT_MOTOR_CHAR = 4'h8;
   // time after which a partial frame is dropped
   localparam int FRAME_GAP_NS = 1000000;
   localparam int CLK_PERIOD_NS = 4;

   // status word layout, msb first
   typedef struct packed {
      logic [3:0] fault_code;  // bits 15..12
      logic [4:0] reserved;    // bits 11..7, read zero
      logic shutdown_state;    // bit 6
      logic option_fitted;     // bit 5
      logic output1;           // bit 4
      logic [3:0] inputs;      // bits 3..0
   } dssa_status_t;

   typedef struct packed {
      logic [15:0] checksum;
      logic [15:0] value;
      logic [7:0] index;
      logic [7:0] addr;
   } dssa_frame_t;

   typedef enum logic [1:0] {
      ST_RECEIVE = 2'b01,
      ST_REPLY = 2'b10
   } dssa_state_t;

   // checksum is the 16-bit sum of the four leading frame bytes
   function automatic logic [15:0] dssa_frame_checksum(input logic [7:0] a, input logic [7:0] i,
                                              input logic [15:0] v);
      dssa_frame_checksum = 16'({8'h00, a}) + 16'({8'h00, i}) + 16'({8'h00, v[7:0]})
                   + 16'({8'h00, v[15:8]});
   endfunction
endpackage

// *** dssa_sync.sv ***
// module: two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dssa_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** dssa_host.sv ***
// host-side partner model: sends parameter frames, takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module dssa_host (
   input wire logic clk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   logic [7:0] rep [6];
   logic got;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
      got = 1'b0;
   end
   // one byte per cycle; ck_err flips checksum bits to make a bad frame
   task automatic send(input logic [7:0] a, input logic [7:0] i, input logic [15:0] v,
                       input logic [15:0] ck_err);
      logic [15:0] ck;
      logic [7:0] b [6];
      ck = (16'(a) + 16'(i) + 16'(v[7:0]) + 16'(v[15:8])) ^ ck_err;
      b = '{a, i, v[7:0], v[15:8], ck[7:0], ck[15:8]};
      foreach (b[k]) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = b[k];
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data; // released line must not keep the last byte
   endtask
   // a cut frame: only the first n bytes, the rest never follows
   task automatic send_part(input logic [7:0] a, input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = a;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
   // slow mode stalls one cycle between bytes; gives up after 40 idle cycles
   task automatic take(input logic slow);
      int w;
      got = 1'b0;
      for (int k = 0; k < 6; k++) begin
         w = 0;
         while (tx_valid !== 1'b1 && w < 40) begin
            @(negedge clk);
            w++;
         end
         if (w >= 40) return;
         rep[k] = tx_data;
         tx_ready = 1'b1;
         @(negedge clk);
         if (slow || k == 5) begin
            tx_ready = 1'b0;
            if (slow) @(negedge clk);
         end
      end
      got = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** dssa_bank_tb.sv ***
// testbench: drive parameter bank against the host model
`timescale 1ns/1ps
`default_nettype none
module dssa_bank_tb;
   import dssa_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic rx_valid, tx_valid, tx_ready, option_pin, shutdown_pin, output1_state, drive_disable;
   logic [7:0] rx_data, tx_data, node_address;
   logic [3:0] input_pins = 4'h0;
   logic [3:0] fault_code = 4'h0;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   initial begin
      option_pin = 1'b0;
      shutdown_pin = 1'b0;
      output1_state = 1'b0;
   end
   always #2 clk = ~clk;
   dssa_bank #(.GAP_CYCLES(50)) uut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .input_pins(input_pins), .option_pin(option_pin), .shutdown_pin(shutdown_pin),
      .output1_state(output1_state), .fault_code(fault_code),
      .drive_disable(drive_disable), .node_address(node_address));
   dssa_host host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // whole run is under a thousand cycles; a hang ends here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // one answered frame: reply value and reply checksum compared
   task automatic xfer(input logic [7:0] a, input logic [7:0] i, input logic [15:0] v,
                       input logic [15:0] ev);
      host.send(a, i, v, 16'h0000);
      host.take(i[0]);
      chk({15'h0, host.got}, 16'h0001);
      chk({host.rep[1], host.rep[0]}, {i, a});
      chk({host.rep[3], host.rep[2]}, ev);
      chk({host.rep[5], host.rep[4]}, 16'(a) + 16'(i) + 16'(ev[7:0]) + 16'(ev[15:8]));
   endtask
   // a frame that must get no reply at all
   task automatic silent(input logic [7:0] a, input logic [7:0] i, input logic [15:0] ce);
      host.send(a, i, 16'h0000, ce);
      host.take(1'b0);
      chk({15'h0, host.got}, 16'h0000);
   endtask
   task automatic t_reset;
      chk({8'h00, node_address}, 16'h0001);
      chk({15'h0, drive_disable}, 16'h0000);
      xfer(8'h01, 8'hf7, 16'h0000, 16'h0000);
      xfer(8'h01, 8'hf6, 16'h0000, 16'h0001);
   endtask
   // every fault code, with mixed pin levels in the low byte
   task automatic t_status;
      @(negedge clk);
      input_pins = 4'ha;
      output1_state = 1'b1;
      option_pin = 1'b1;
      for (int f = 0; f < 16; f++) begin
         fault_code = 4'(f);
         repeat (5) @(negedge clk);
         xfer(8'h01, 8'hf4, 16'h0000, {4'(f), 12'h03a});
      end
   endtask
   task automatic t_override;
      xfer(8'h01, 8'h77, 16'h0001, 16'h0001);
      chk({15'h0, drive_disable}, 16'h0001);
      // pin level must not matter while the override is set
      shutdown_pin = 1'b1;
      repeat (4) @(negedge clk);
      chk({15'h0, drive_disable}, 16'h0001);
      shutdown_pin = 1'b0;
      repeat (4) @(negedge clk);
      chk({15'h0, drive_disable}, 16'h0001);
      xfer(8'h01, 8'hf4, 16'h0000, 16'hf07a);
      xfer(8'h01, 8'h77, 16'h0000, 16'h0000);
      chk({15'h0, drive_disable}, 16'h0000);
      shutdown_pin = 1'b1;
      repeat (4) @(negedge clk);
      chk({15'h0, drive_disable}, 16'h0001);
      shutdown_pin = 1'b0;
      repeat (4) @(negedge clk);
      chk({15'h0, drive_disable}, 16'h0000);
   endtask
   // address change, then stale address, bad sum, unknown index, zero address
   task automatic t_addr;
      xfer(8'h01, 8'h76, 16'h0005, 16'h0005);
      chk({8'h00, node_address}, 16'h0005);
      silent(8'h01, 8'hf6, 16'h0000);
      silent(8'h05, 8'hf6, 16'h0100);
      silent(8'h05, 8'hf5, 16'h0000);
      xfer(8'h05, 8'h76, 16'h0000, 16'h0005);
      xfer(8'h05, 8'h77, 16'h0001, 16'h0001);
   endtask
   // reset in mid-run clears the override and sets the address back to 1
   task automatic t_reset2;
      resetn = 1'b0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      chk({15'h0, drive_disable}, 16'h0000);
      chk({8'h00, node_address}, 16'h0001);
      xfer(8'h01, 8'hf7, 16'h0000, 16'h0000);
   endtask
   // a cut frame is dropped after the idle gap, so the next frame lines up
   task automatic t_gap;
      host.send_part(8'h01, 3);
      repeat (60) @(negedge clk);
      xfer(8'h01, 8'hf6, 16'h0000, 16'h0001);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      t_reset();
      t_status();
      t_override();
      t_addr();
      t_reset2();
      t_gap();
      tally_and_finish();
   end
endmodule
`default_nettype wire
